//--- design/ots_regs.svh
// Register map, field positions, reset values and timing constants
`ifndef OTS_REGS_SVH
`define OTS_REGS_SVH

// ****************************************************************
// Bus geometry
// ****************************************************************
`define OTS_AXI_AW 4
`define OTS_RESP_OKAY 2'b00
`define OTS_RESP_DECERR 2'b11

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OTS_REG_CTRL 4'h0
`define OTS_REG_STAT 4'h4
`define OTS_REG_MASK 4'h8
`define OTS_REG_LIVE 4'hc

// ****************************************************************
// Control register fields
// ****************************************************************
`define OTS_CTRL_CHG 0
`define OTS_CTRL_DSG 1
`define OTS_CTRL_AUTO_DIS 2
`define OTS_CTRL_FORCE 3
`define OTS_CTRL_INT_OFF 4
`define OTS_CTRL_EXT_OFF 5
`define OTS_CTRL_SEL_LO 8
`define OTS_CTRL_SEL_HI 11
`define OTS_CTRL_RST 32'h0000_0000
`define OTS_SEL_EXT_TEMP 4'h8
`define OTS_SEL_RST 4'h0

// ****************************************************************
// Status / mask fields, also the input synchroniser lanes
// ****************************************************************
`define OTS_ST_W 5
`define OTS_ST_IOT 0
`define OTS_ST_XOT 1
`define OTS_ST_COC 2
`define OTS_ST_DOC 3
`define OTS_ST_DSC 4
`define OTS_ST_RST 5'h00
`define OTS_SY_BELOW 0
`define OTS_SY_INT 1
`define OTS_SY_COC 2
`define OTS_SY_DOC 3
`define OTS_SY_DSC 4

// ****************************************************************
// Live state register fields
// ****************************************************************
`define OTS_LV_SUPPLY 0
`define OTS_LV_SHUT 1
`define OTS_LV_EXTFAIL 2
`define OTS_LV_SETTLED 3
`define OTS_LV_INTOT 4

// ****************************************************************
// Timing
// ****************************************************************
`define OTS_CLK_MHZ 25
`define OTS_SCAN_ON_US 5000
`define OTS_SCAN_PERIOD_US 640000
`define OTS_SETTLE_US 1000
`define OTS_CNT_W 24

`endif

//--- design/ots_pkg.sv
// Shared types and helper functions of the over-temperature scan block
`include "ots_regs.svh"

package ots_pkg;

  // Bus channel phase
  typedef enum logic {
    OTS_PH_IDLE = 1'b0,
    OTS_PH_RESP = 1'b1
  } ots_ph_t;

  typedef logic [`OTS_CNT_W-1:0] ots_cnt_t;

  // Bus slave state
  typedef struct packed {
    ots_ph_t wph;
    ots_ph_t rph;
    logic aw_ok;
    logic w_ok;
    logic [`OTS_AXI_AW-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ots_axs_t;

  // Core state
  typedef struct packed {
    logic [`OTS_ST_W-1:0] sync1;
    logic [`OTS_ST_W-1:0] sync2;
    logic chg_ctl;
    logic dsg_ctl;
    logic auto_dis;
    logic force_on;
    logic int_off;
    logic ext_off;
    logic [3:0] sel;
    logic [`OTS_ST_W-1:0] status;
    logic [`OTS_ST_W-1:0] mask;
    ots_cnt_t scan_cnt;
    ots_cnt_t settle_cnt;
    logic supply;
    logic settled;
    logic ext_fail;
    logic chg_out;
    logic dsg_out;
    logic route_ext;
    logic irq;
  } ots_core_t;

  // Address decode shared by write and read paths
  function automatic logic ots_addr_hit(input logic [`OTS_AXI_AW-1:0] a);
    ots_addr_hit = (a == `OTS_REG_CTRL) || (a == `OTS_REG_STAT) ||
                   (a == `OTS_REG_MASK) || (a == `OTS_REG_LIVE);
  endfunction

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] ots_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    ots_merge = (old_v & ~m) | (new_v & m);
  endfunction

endpackage

//--- design/ots_axil_slave.sv
// AXI4-Lite slave front end: channel handshakes, one write strobe
`timescale 1ns/1ps
`include "ots_regs.svh"

module ots_axil_slave
  import ots_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`OTS_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`OTS_AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic reg_wr_en,
  output logic [`OTS_AXI_AW-1:0] reg_wr_addr,
  output logic [31:0] reg_wr_data,
  output logic [3:0] reg_wr_strb,
  output logic [`OTS_AXI_AW-1:0] reg_rd_addr,
  input wire logic [31:0] reg_rd_data
);

  ots_axs_t s_q;
  ots_axs_t s_d;

  // ****************************************************************
  // Handshake outputs
  // ****************************************************************
  // Each channel is held off while its item waits for its partner
  assign s_axi_awready = (s_q.wph == OTS_PH_IDLE) && !s_q.aw_ok;
  assign s_axi_wready = (s_q.wph == OTS_PH_IDLE) && !s_q.w_ok;
  assign s_axi_bvalid = (s_q.wph == OTS_PH_RESP);
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = (s_q.rph == OTS_PH_IDLE);
  assign s_axi_rvalid = (s_q.rph == OTS_PH_RESP);
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign reg_wr_en = (s_q.wph == OTS_PH_IDLE) && s_q.aw_ok && s_q.w_ok;
  assign reg_wr_addr = s_q.waddr;
  assign reg_wr_data = s_q.wdata;
  assign reg_wr_strb = s_q.wstrb;
  assign reg_rd_addr = s_axi_araddr;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Write path: collect both halves in any order, commit, respond
  always_comb begin
    s_d = s_q;
    unique case (s_q.wph)
      OTS_PH_IDLE: begin
        if (s_axi_awvalid && s_axi_awready) begin
          s_d.aw_ok = 1'b1;
          s_d.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          s_d.w_ok = 1'b1;
          s_d.wdata = s_axi_wdata;
          s_d.wstrb = s_axi_wstrb;
        end
        if (reg_wr_en) begin
          s_d.aw_ok = 1'b0;
          s_d.w_ok = 1'b0;
          s_d.wph = OTS_PH_RESP;
          s_d.bresp = ots_addr_hit(s_q.waddr) ? `OTS_RESP_OKAY :
                                                `OTS_RESP_DECERR;
        end
      end
      OTS_PH_RESP: begin
        if (s_axi_bready) begin
          s_d.wph = OTS_PH_IDLE;
        end
      end
    endcase
    // Read path: data is captured when the address is taken
    unique case (s_q.rph)
      OTS_PH_IDLE: begin
        if (s_axi_arvalid) begin
          s_d.rph = OTS_PH_RESP;
          s_d.rdata = ots_addr_hit(s_axi_araddr) ? reg_rd_data : 32'h0;
          s_d.rresp = ots_addr_hit(s_axi_araddr) ? `OTS_RESP_OKAY :
                                                   `OTS_RESP_DECERR;
        end
      end
      OTS_PH_RESP: begin
        if (s_axi_rready) begin
          s_d.rph = OTS_PH_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

//--- design/ots_top.sv
// Thermistor scan, over-temperature shutdown and monitor select core
// Functional notes
// - Auto scan: supply on 5 ms per 640 ms
// - Wait 1 ms settling before comparing
// - Below reference after settling flags external fail
// - External select keeps supply on, routes sense
// - External select detects only after 1 ms
// - Disable bit stops auto scan only
// - Auto and manual scans coexist undisturbed
// - Force bit keeps supply permanently on
// - Overtemp turns switches off, sets flag
// - Switches held off until temperature recovers
// - Switch writes ignored during shutdown
// - Internal response disable blocks internal shutdown
// - External response disable blocks external shutdown
// - Select field routes chosen monitor quantity
// - Overcurrent flags also turn supply on
// - Protection shutdown clears switch control bits
`timescale 1ns/1ps
`include "ots_regs.svh"

module ots_top
  import ots_pkg::*;
#(
  parameter int SCAN_ON_CYC = `OTS_SCAN_ON_US * `OTS_CLK_MHZ,
  parameter int SCAN_PERIOD_CYC = `OTS_SCAN_PERIOD_US * `OTS_CLK_MHZ,
  parameter int SETTLE_CYC = `OTS_SETTLE_US * `OTS_CLK_MHZ
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`OTS_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`OTS_AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic thermistor_sense_below,
  input wire logic internal_overtemp_in,
  input wire logic charge_overcurrent_in,
  input wire logic discharge_overcurrent_in,
  input wire logic short_circuit_in,
  output logic thermistor_supply_out,
  output logic [3:0] monitor_select_field,
  output logic monitor_route_ext_temp,
  output logic charge_switch_out,
  output logic discharge_switch_out,
  output logic irq
);

  // ****************************************************************
  // Derived counts
  // ****************************************************************
  localparam ots_cnt_t ON_LAST = ots_cnt_t'(SCAN_ON_CYC - 1);
  localparam ots_cnt_t PER_LAST = ots_cnt_t'(SCAN_PERIOD_CYC - 1);
  localparam ots_cnt_t SET_LAST = ots_cnt_t'(SETTLE_CYC - 1);

  ots_core_t c_q;
  ots_core_t c_d;
  logic wr_en;
  logic [`OTS_AXI_AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [`OTS_AXI_AW-1:0] rd_addr;
  logic [31:0] rd_data;
  logic [31:0] ctrl_word;
  logic [31:0] ctrl_new;
  logic [31:0] mask_new;
  logic [`OTS_ST_W-1:0] st_clr;
  logic [`OTS_ST_W-1:0] st_set;
  logic auto_win;
  logic ext_sel;
  logic oc_any;
  logic supply_req;
  logic int_ot;
  logic shut;

  // ****************************************************************
  // Register bus slave
  // ****************************************************************
  ots_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .reg_wr_en(wr_en),
    .reg_wr_addr(wr_addr),
    .reg_wr_data(wr_data),
    .reg_wr_strb(wr_strb),
    .reg_rd_addr(rd_addr),
    .reg_rd_data(rd_data)
  );

  // ****************************************************************
  // Register views
  // ****************************************************************
  // Control word as software sees it
  always_comb begin
    ctrl_word = `OTS_CTRL_RST;
    ctrl_word[`OTS_CTRL_CHG] = c_q.chg_ctl;
    ctrl_word[`OTS_CTRL_DSG] = c_q.dsg_ctl;
    ctrl_word[`OTS_CTRL_AUTO_DIS] = c_q.auto_dis;
    ctrl_word[`OTS_CTRL_FORCE] = c_q.force_on;
    ctrl_word[`OTS_CTRL_INT_OFF] = c_q.int_off;
    ctrl_word[`OTS_CTRL_EXT_OFF] = c_q.ext_off;
    ctrl_word[`OTS_CTRL_SEL_HI:`OTS_CTRL_SEL_LO] = c_q.sel;
  end

  // Read mux; unmapped offsets are answered by the slave
  always_comb begin
    rd_data = 32'h0;
    unique case (rd_addr)
      `OTS_REG_CTRL: rd_data = ctrl_word;
      `OTS_REG_STAT: rd_data[`OTS_ST_W-1:0] = c_q.status;
      `OTS_REG_MASK: rd_data[`OTS_ST_W-1:0] = c_q.mask;
      `OTS_REG_LIVE: begin
        rd_data[`OTS_LV_SUPPLY] = c_q.supply;
        rd_data[`OTS_LV_SHUT] = shut;
        rd_data[`OTS_LV_EXTFAIL] = c_q.ext_fail;
        rd_data[`OTS_LV_SETTLED] = c_q.settled;
        rd_data[`OTS_LV_INTOT] = int_ot;
      end
      default: rd_data = 32'h0;
    endcase
  end

  // Byte-merged write values
  assign ctrl_new = ots_merge(ctrl_word, wr_data, wr_strb);
  assign mask_new = ots_merge({{(32-`OTS_ST_W){1'b0}}, c_q.mask},
                              wr_data, wr_strb);

  // ****************************************************************
  // Supply requests and protection levels
  // ****************************************************************
  // Auto window is the first part of each period
  assign auto_win = !c_q.auto_dis && (c_q.scan_cnt <= ON_LAST);
  assign ext_sel = (c_q.sel == `OTS_SEL_EXT_TEMP);
  assign oc_any = c_q.status[`OTS_ST_COC] | c_q.status[`OTS_ST_DOC] |
                  c_q.status[`OTS_ST_DSC];
  // Any one source is enough, so sources never disturb each other
  assign supply_req = auto_win | ext_sel | c_q.force_on | oc_any;
  assign int_ot = c_q.sync2[`OTS_SY_INT];
  // Shutdown is a level: it lasts while a trip condition persists
  assign shut = (int_ot && !c_q.int_off) ||
                (c_q.ext_fail && !c_q.ext_off);

  // Status: hardware set wins over a same-cycle write-one clear
  assign st_set = {c_q.sync2[`OTS_SY_DSC], c_q.sync2[`OTS_SY_DOC],
                   c_q.sync2[`OTS_SY_COC], c_q.ext_fail, int_ot};
  assign st_clr = (wr_en && wr_addr == `OTS_REG_STAT) ?
                  (wr_data[`OTS_ST_W-1:0] &
                   {{(`OTS_ST_W-1){wr_strb[0]}}, wr_strb[0]}) :
                  `OTS_ST_RST;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    c_d = c_q;
    // Two-stage synchronisers for pin inputs
    c_d.sync1 = {short_circuit_in, discharge_overcurrent_in,
                 charge_overcurrent_in, internal_overtemp_in,
                 thermistor_sense_below};
    c_d.sync2 = c_q.sync1;
    // Period counter idles at zero while the auto scan is off
    if (c_q.auto_dis) begin
      c_d.scan_cnt = '0;
    end else if (c_q.scan_cnt >= PER_LAST) begin
      c_d.scan_cnt = '0;
    end else begin
      c_d.scan_cnt = c_q.scan_cnt + ots_cnt_t'(1);
    end
    c_d.supply = supply_req;
    // Settling timer restarts only when the supply truly goes off
    if (!c_q.supply) begin
      c_d.settle_cnt = '0;
      c_d.settled = 1'b0;
    end else if (c_q.settle_cnt >= SET_LAST) begin
      c_d.settled = 1'b1;
    end else begin
      c_d.settle_cnt = c_q.settle_cnt + ots_cnt_t'(1);
    end
    // Compare only on a settled supply; hold between scans
    if (c_q.settled) begin
      c_d.ext_fail = c_q.sync2[`OTS_SY_BELOW];
    end
    // Control register writes
    if (wr_en && wr_addr == `OTS_REG_CTRL) begin
      if (!shut) begin
        c_d.chg_ctl = ctrl_new[`OTS_CTRL_CHG];
        c_d.dsg_ctl = ctrl_new[`OTS_CTRL_DSG];
      end
      c_d.auto_dis = ctrl_new[`OTS_CTRL_AUTO_DIS];
      c_d.force_on = ctrl_new[`OTS_CTRL_FORCE];
      c_d.int_off = ctrl_new[`OTS_CTRL_INT_OFF];
      c_d.ext_off = ctrl_new[`OTS_CTRL_EXT_OFF];
      c_d.sel = ctrl_new[`OTS_CTRL_SEL_HI:`OTS_CTRL_SEL_LO];
    end
    if (wr_en && wr_addr == `OTS_REG_MASK) begin
      c_d.mask = mask_new[`OTS_ST_W-1:0];
    end
    // A protection shutdown clears the software switch bits
    if (shut) begin
      c_d.chg_ctl = 1'b0;
      c_d.dsg_ctl = 1'b0;
    end
    c_d.status = (c_q.status & ~st_clr) | st_set;
    // Outputs follow from the next state so they line up
    c_d.chg_out = c_d.chg_ctl && !shut;
    c_d.dsg_out = c_d.dsg_ctl && !shut;
    c_d.route_ext = (c_d.sel == `OTS_SEL_EXT_TEMP);
    c_d.irq = |(c_d.status & c_d.mask);
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c_q <= '0;
    end else begin
      c_q <= c_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign thermistor_supply_out = c_q.supply;
  assign monitor_select_field = c_q.sel;
  assign monitor_route_ext_temp = c_q.route_ext;
  assign charge_switch_out = c_q.chg_out;
  assign discharge_switch_out = c_q.dsg_out;
  assign irq = c_q.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Start of an auto scan window
  sequence s_win_start;
    !c_q.auto_dis && c_q.scan_cnt == '0;
  endsequence

  // Supply held for the first cycles of a window; a disable write
  // in mid-window may legally cut it one cycle later
  sequence s_supply_run;
    (c_q.supply || $past(c_q.auto_dis)) [*4];
  endsequence

  AST_SCAN_WINDOW: assert property (
    s_win_start ##0 (ON_LAST >= ots_cnt_t'(4)) |=> s_supply_run)
    else $error("auto scan window did not drive the supply");

  AST_SCAN_PERIOD: assert property (
    !c_q.auto_dis && c_q.scan_cnt == PER_LAST |=> c_q.scan_cnt == '0)
    else $error("auto scan period did not wrap");

  AST_SUPPLY_IDLE: assert property (
    !supply_req |=> !c_q.supply)
    else $error("supply on with no request");

  AST_FORCE_ON: assert property (
    c_q.force_on |=> c_q.supply)
    else $error("force bit did not hold the supply on");

  // Routing follows the select in the same cycle, the supply one later
  AST_EXT_SEL: assert property (
    ext_sel |-> c_q.route_ext ##1 c_q.supply)
    else $error("external select lost supply or routing");

  AST_OC_WAKE: assert property (
    oc_any |=> c_q.supply)
    else $error("overcurrent flag did not wake the supply");

  AST_SETTLE_GATE: assert property (
    $changed(c_q.ext_fail) |-> $past(c_q.settled))
    else $error("comparison taken before settling");

  AST_SETTLE_TIME: assert property (
    $rose(c_q.settled) |-> $past(c_q.settle_cnt) >= SET_LAST)
    else $error("settle time too short");

  AST_EXT_COMPARE: assert property (
    c_q.settled && c_q.sync2[`OTS_SY_BELOW] |=> c_q.ext_fail)
    else $error("settled low reading missed");

  AST_INT_TRIP: assert property (
    int_ot && !c_q.int_off |=> !c_q.chg_out && !c_q.dsg_out
      && c_q.status[`OTS_ST_IOT])
    else $error("internal overtemp did not shut down");

  AST_EXT_HOLD: assert property (
    c_q.ext_fail && !c_q.ext_off |=> !c_q.chg_out && !c_q.dsg_out)
    else $error("switches on during external shutdown");

  AST_CTRL_CLEAR: assert property (
    shut |=> !c_q.chg_ctl && !c_q.dsg_ctl)
    else $error("switch bits survived a shutdown");

  AST_FLAG_STICKY: assert property (
    c_q.status[`OTS_ST_XOT] && !st_clr[`OTS_ST_XOT]
    |=> c_q.status[`OTS_ST_XOT])
    else $error("external overtemp flag dropped by itself");

  AST_AUTO_OFF: assert property (
    c_q.auto_dis |=> c_q.scan_cnt == '0)
    else $error("auto scan ran while disabled");

endmodule

//--- test/ots_therm_model.sv
// Thermistor divider and comparator model on the far side of the block
`timescale 1ns/1ps

module ots_therm_model (
  input wire logic aclk,
  input wire logic supply_on,
  input wire logic hot,
  output logic sense_below
);
  logic last_q = 1'b0;

  // Unpowered divider has no valid level: toggle so stale reads show
  always_ff @(posedge aclk) begin
    if (supply_on) begin
      last_q <= hot;
    end else begin
      last_q <= ~last_q;
    end
  end
  assign sense_below = last_q;
endmodule

//--- test/testbench.sv
// Self-checking bench of the over-temperature scan block
`timescale 1ns/1ps
`include "ots_regs.svh"

module testbench;
  localparam int PER = 40;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic hot = 1'b0, int_ot = 1'b0;
  logic [2:0] oc = 3'h0;
  logic [1:0] resp_v;
  wire logic awready, wready, bvalid, arready, rvalid, sense;
  wire logic supply, route, chg, dsg, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [3:0] sel;
  int mismatches = 0;
  int total_checks = 0;

  // Clock of 40 ns
  initial forever #20 aclk = ~aclk;

  ots_top #(.SCAN_ON_CYC(8), .SCAN_PERIOD_CYC(PER), .SETTLE_CYC(4)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .thermistor_sense_below(sense), .internal_overtemp_in(int_ot),
    .charge_overcurrent_in(oc[0]), .discharge_overcurrent_in(oc[1]),
    .short_circuit_in(oc[2]), .thermistor_supply_out(supply),
    .monitor_select_field(sel), .monitor_route_ext_temp(route),
    .charge_switch_out(chg), .discharge_switch_out(dsg), .irq(irq)
  );

  ots_therm_model partner (.aclk(aclk), .supply_on(supply), .hot(hot),
    .sense_below(sense));

  // ****
  // Shared tasks
  // ****
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Outputs are sampled at the falling edge, away from updates
  task automatic cyc(input int n);
    repeat (n) @(negedge aclk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    logic aw_r, w_r, b_r;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw_r = awready & awvalid;
      w_r = wready & wvalid;
      b_r = (bvalid === 1'b1);
      resp_v = bresp;
      @(posedge aclk);
      if (aw_r) awvalid <= 1'b0;
      if (w_r) wvalid <= 1'b0;
      n++;
    end while (!b_r && n < 50);
    bready <= 1'b0;
    chk(32'(b_r), 32'h1);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    int n;
    logic a_r, r_r;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      a_r = arready & arvalid;
      r_r = (rvalid === 1'b1);
      d = rdata;
      resp_v = rresp;
      @(posedge aclk);
      if (a_r) arvalid <= 1'b0;
      n++;
    end while (!r_r && n < 50);
    rready <= 1'b0;
    chk(32'(r_r), 32'h1);
  endtask

  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask

  // Any span of one period holds the same count of supply cycles
  task automatic cnt_sup(input logic [31:0] e);
    int c;
    c = 0;
    repeat (PER) begin
      @(negedge aclk);
      c += (supply === 1'b1);
    end
    chk(32'(c), e);
  endtask

  task automatic sw(input logic [31:0] e);
    chk(32'({chg, dsg}), e);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    rc(`OTS_REG_CTRL, 32'h0);
    rc(`OTS_REG_STAT, 32'h0);
    rc(4'h2, 32'h0);
    chk(32'(resp_v), 32'h3);
    wr(4'h6, 32'hffff_ffff);
    chk(32'(resp_v), 32'h3);
    rc(`OTS_REG_CTRL, 32'h0);
  endtask

  task automatic t_scan;
    cnt_sup(32'd8);
    wr(`OTS_REG_CTRL, 32'h4);
    cyc(8);
    cnt_sup(32'd0);
    wr(`OTS_REG_CTRL, 32'hc);
    cnt_sup(32'd40);
    wr(`OTS_REG_CTRL, 32'h4);
    cyc(2);
    chk(32'(supply), 32'h0);
  endtask

  task automatic t_wake;
    for (int i = 0; i < 3; i++) begin
      @(posedge aclk) oc <= 3'h1 << i;
      cyc(3);
      @(posedge aclk) oc <= 3'h0;
      cyc(4);
      chk(32'(supply), 32'h1);
      rc(`OTS_REG_STAT, 32'h4 << i);
      wr(`OTS_REG_STAT, 32'h1f);
      cyc(3);
      chk(32'(supply), 32'h0);
    end
  endtask

  task automatic t_irq;
    wr(`OTS_REG_MASK, 32'h4);
    @(posedge aclk) oc <= 3'h1;
    cyc(3);
    @(posedge aclk) oc <= 3'h0;
    cyc(3);
    chk(32'(irq), 32'h1);
    wr(`OTS_REG_MASK, 32'h0);
    cyc(1);
    chk(32'(irq), 32'h0);
    wr(`OTS_REG_MASK, 32'h4);
    cyc(1);
    chk(32'(irq), 32'h1);
    wr(`OTS_REG_STAT, 32'h4);
    cyc(1);
    chk(32'(irq), 32'h0);
  endtask

  task automatic t_ext;
    wr(`OTS_REG_CTRL, 32'h7);
    @(posedge aclk) hot <= 1'b1;
    wr(`OTS_REG_CTRL, 32'h807);
    cyc(1);
    chk(32'({sel, route, supply}), 32'h23);
    sw(32'h3);
    cyc(8);
    sw(32'h0);
    rc(`OTS_REG_STAT, 32'h2);
    rc(`OTS_REG_LIVE, 32'hf);
    rc(`OTS_REG_CTRL, 32'h804);
    wr(`OTS_REG_CTRL, 32'h807);
    rc(`OTS_REG_CTRL, 32'h804);
    chk(32'({sel, chg, dsg}), 32'h20);
    @(posedge aclk) hot <= 1'b0;
    cyc(8);
    wr(`OTS_REG_CTRL, 32'h807);
    cyc(1);
    sw(32'h3);
    rc(`OTS_REG_STAT, 32'h2);
    wr(`OTS_REG_STAT, 32'h2);
    rc(`OTS_REG_STAT, 32'h0);
    wr(`OTS_REG_CTRL, 32'h827);
    @(posedge aclk) hot <= 1'b1;
    cyc(10);
    sw(32'h3);
    rc(`OTS_REG_STAT, 32'h2);
    @(posedge aclk) hot <= 1'b0;
    cyc(8);
    wr(`OTS_REG_STAT, 32'h2);
    wr(`OTS_REG_CTRL, 32'h7);
  endtask

  task automatic t_int;
    @(posedge aclk) int_ot <= 1'b1;
    cyc(4);
    sw(32'h0);
    rc(`OTS_REG_STAT, 32'h1);
    @(posedge aclk) int_ot <= 1'b0;
    cyc(4);
    wr(`OTS_REG_STAT, 32'h1);
    wr(`OTS_REG_CTRL, 32'h17);
    @(posedge aclk) int_ot <= 1'b1;
    cyc(6);
    sw(32'h3);
    @(posedge aclk) int_ot <= 1'b0;
    cyc(4);
    wr(`OTS_REG_STAT, 32'h1);
  endtask

  task automatic t_mix;
    wr(`OTS_REG_CTRL, 32'h800);
    cnt_sup(32'd40);
    wr(`OTS_REG_CTRL, 32'h0);
    cnt_sup(32'd8);
  endtask

  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog: the whole run needs under 3000 cycles
  initial begin
    #400000;
    mismatches++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_scan();
    t_wake();
    t_irq();
    t_ext();
    t_int();
    t_mix();
    report_and_stop();
  end
endmodule
